// ### rtl/aopc_path.sv
// Purpose: Output path of a stereo ADC: DC filter, saturation, mixing, control registers.
// Assumes: Control port front end decodes I2C/SPI into a byte register strobe port.
// Notes:   Mode strap latched once after reset release, master strap followed live in strapped mode; samples buffered two deep.
// Functional notes
// - Host controls everything through register port
// - Strapped mode uses pins, registers ignored
// - Power-down bits in two registers
// - Strapped mode: boosts, ramps off, 0 dB
// - Strapped mode: filter on, not frozen
// - Strapped mode: role follows strap pin
// - Output samples are two's complement
// - Saturate to full scale, set overflow
// - Fixed offset added, never removed
// - Filter off: DC relative to midsupply
// - Filter on: estimate and subtract DC
// - Frozen: hold estimate, keep subtracting
// - Separate enable and freeze per channel
// - Per-channel volume, mono mix, swap
// - Exactly one of four speed modes
`timescale 1ns/1ps
`include "aopc_defines.svh"
module aopc_path
	import aopc_pkg::*;
#(
	parameter int W = 24
) (
	input  wire logic          clock,        // Converter clock, 10 MHz
	input  wire logic          rst_b,        // Async reset, active low
	input  wire logic          hw_mode_pin,  // Strap: high selects pin-strapped mode
	input  wire logic          master_pin,   // Strap: serial port master role
	input  wire aopc_reg_req_type reg_req,   // Register access from control port
	output logic      [7:0]    reg_rdata,    // Read data, valid cycle after rd
	input  wire aopc_pair_type dec_data,     // Decimator output pair
	input  wire logic          dec_valid,    // Decimator pair valid
	output logic               dec_ready,    // Buffer can take a pair
	output aopc_pair_type      out_data,     // Pair to serial port
	output logic               out_valid,    // Output pair valid
	input  wire logic          out_ready,    // Serial port takes pair
	output logic      [7:0]    power1_r,     // Power-down controls 1
	output logic      [7:0]    power2_r,     // Power-down controls 2
	output logic               sp_master_r,  // Serial port master role
	output logic      [1:0]    speed_r,      // Speed mode
	output logic               hw_mode_r     // Pin-strapped mode active
);
	logic       rs1_r, rs_b;
	logic [2:0] hw_sync_r, ms_sync_r;
	logic       strap_done_r;
	logic [2:0] strap_fill_r;
	logic [7:0] ctrl_r, status_r, spe_r, vola_r, volb_r;
	logic [W+1:0] est_a_r, est_b_r;
	aopc_pair_type buf_r [2];
	logic       wp_r, rp_r;
	logic [1:0] cnt_r;
	logic       sp_cfg_r;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rs1_r <= 1'b0;
			rs_b  <= 1'b0;
		end else begin
			rs1_r <= 1'b1;
			rs_b  <= rs1_r;
		end
	end

	// Straps: three flops, accepted when last two agree
	always_ff @(posedge clock or negedge rs_b) begin
		if (!rs_b) begin
			hw_sync_r    <= 3'h0;
			ms_sync_r    <= 3'h0;
			strap_fill_r <= 3'h0;
		end else begin
			hw_sync_r    <= {hw_sync_r[1:0], hw_mode_pin};
			ms_sync_r    <= {ms_sync_r[1:0], master_pin};
			strap_fill_r <= {strap_fill_r[1:0], 1'b1};
		end
	end
	wire strap_ok = (hw_sync_r[2] == hw_sync_r[1]) && (ms_sync_r[2] == ms_sync_r[1]);
	// Reset zeros in the chain must not be latched as a strap value
	wire strap_cnt_go = !strap_done_r && strap_ok && strap_fill_r[2];

	// Power-up latch of the mode; hardware mode is fixed until reset
	always_ff @(posedge clock or negedge rs_b) begin
		if (!rs_b) begin
			strap_done_r <= 1'b0;
			hw_mode_r    <= 1'b0;
		end else if (strap_cnt_go) begin
			strap_done_r <= 1'b1;
			hw_mode_r    <= hw_sync_r[2];
		end
	end

	wire wr_ok   = reg_req.wr && !hw_mode_r && strap_done_r;
	wire wr_ctrl = wr_ok && reg_req.addr == `AOPC_OFF_CTRL;
	wire wr_p1   = wr_ok && reg_req.addr == `AOPC_OFF_POWER1;
	wire wr_p2   = wr_ok && reg_req.addr == `AOPC_OFF_POWER2;
	wire wr_spe  = wr_ok && reg_req.addr == `AOPC_OFF_SPE;
	wire wr_va   = wr_ok && reg_req.addr == `AOPC_OFF_VOLA;
	wire wr_vb   = wr_ok && reg_req.addr == `AOPC_OFF_VOLB;
	wire wr_spd  = wr_ok && reg_req.addr == `AOPC_OFF_SPEED;
	wire rd_stat = reg_req.rd && reg_req.addr == `AOPC_OFF_STATUS;
	wire enter_hw = strap_cnt_go && hw_sync_r[2];

	always_ff @(posedge clock or negedge rs_b) begin
		if (!rs_b) begin
			ctrl_r      <= `AOPC_CTRL_RST;
			power1_r    <= `AOPC_POWER1_RST;
			power2_r    <= `AOPC_POWER2_RST;
			spe_r       <= `AOPC_SPE_RST;
			vola_r      <= `AOPC_VOL_UNITY;
			volb_r      <= `AOPC_VOL_UNITY;
			speed_r     <= `AOPC_SPEED_RST;
			sp_cfg_r    <= 1'b0;
		end else if (enter_hw) begin
			ctrl_r   <= `AOPC_CTRL_HW;
			power1_r <= `AOPC_POWER1_HW;
			power2_r <= `AOPC_POWER2_HW;
			spe_r    <= `AOPC_SPE_RST;
			vola_r   <= `AOPC_VOL_UNITY;
			volb_r   <= `AOPC_VOL_UNITY;
			speed_r  <= AOPC_SINGLE;
		end else begin
			if (wr_ctrl) ctrl_r <= reg_req.wdata;
			if (wr_p1) power1_r <= reg_req.wdata;
			if (wr_p2) power2_r <= reg_req.wdata;
			if (wr_spe) spe_r <= reg_req.wdata;
			if (wr_va) vola_r <= reg_req.wdata;
			if (wr_vb) volb_r <= reg_req.wdata;
			if (wr_spd) speed_r <= reg_req.wdata[1:0];
			if (wr_spd) sp_cfg_r <= reg_req.wdata[7];
		end
	end

	always_ff @(posedge clock or negedge rs_b) begin
		if (!rs_b) sp_master_r <= 1'b0;
		else sp_master_r <= hw_mode_r ? ms_sync_r[2] : sp_cfg_r;
	end

	// Signed arithmetic helpers
	function automatic logic [W-1:0] sat(input logic [W+1:0] v);
		if (!v[W+1] && v[W:W-1] != 2'b00) sat = `AOPC_SAT_POS;
		else if (v[W+1] && v[W:W-1] != 2'b11) sat = `AOPC_SAT_NEG;
		else sat = v[W-1:0];
	endfunction : sat
	function automatic logic ovf(input logic [W+1:0] v);
		ovf = (v[W+1:W-1] != 3'b000) && (v[W+1:W-1] != 3'b111);
	endfunction : ovf
	function automatic logic [W+1:0] sx(input logic [W-1:0] v);
		sx = {{2{v[W-1]}}, v};
	endfunction : sx
	// Volume is attenuation in 6 dB steps, low three bits
	function automatic logic [W+1:0] vol(input logic [W+1:0] v, input logic [7:0] a);
		vol = $signed(v) >>> a[2:0];
	endfunction : vol

	wire frz_a = ctrl_r[`AOPC_CTRL_FRZ_A];
	wire on_a  = ctrl_r[`AOPC_CTRL_ON_A];
	wire frz_b = ctrl_r[`AOPC_CTRL_FRZ_B];
	wire on_b  = ctrl_r[`AOPC_CTRL_ON_B];
	wire take  = dec_valid && dec_ready;

	// Filter off: raw code, already relative to midsupply
	wire [W+1:0] in_a  = sx(dec_data.left);
	wire [W+1:0] in_b  = sx(dec_data.right);
	wire [W+1:0] hp_a  = on_a ? in_a - est_a_r : in_a;
	wire [W+1:0] hp_b  = on_b ? in_b - est_b_r : in_b;
	wire [W+1:0] of_a  = hp_a + `AOPC_DITHER_OFS;
	wire [W+1:0] of_b  = hp_b + `AOPC_DITHER_OFS;
	wire [W+1:0] v_a   = vol(of_a, vola_r);
	wire [W+1:0] v_b   = vol(of_b, volb_r);
	wire [W+1:0] mono  = ($signed(v_a) + $signed(v_b)) >>> 1;
	wire         swp   = spe_r[`AOPC_SPE_SWAP] && spe_r[`AOPC_SPE_EN];
	wire         mix   = spe_r[`AOPC_SPE_MONO] && spe_r[`AOPC_SPE_EN];
	wire [W+1:0] s_a   = mix ? mono : (swp ? v_b : v_a);
	wire [W+1:0] s_b   = mix ? mono : (swp ? v_a : v_b);
	wire [W+1:0] da_a  = sx(dec_data.left) - est_a_r;
	wire [W+1:0] db_b  = sx(dec_data.right) - est_b_r;
	wire [W+1:0] st_a  = $signed(da_a) >>> `AOPC_HPF_SHIFT;
	wire [W+1:0] st_b  = $signed(db_b) >>> `AOPC_HPF_SHIFT;

	always_ff @(posedge clock or negedge rs_b) begin
		if (!rs_b) begin
			est_a_r <= '0;
			est_b_r <= '0;
		end else if (take) begin
			if (on_a && !frz_a) est_a_r <= est_a_r + st_a;
			if (on_b && !frz_b) est_b_r <= est_b_r + st_b;
		end
	end

	// Overflow: sticky per channel, clear on read, set wins over clear
	wire set_a = take && ovf(s_a);
	wire set_b = take && ovf(s_b);
	always_ff @(posedge clock or negedge rs_b) begin
		if (!rs_b) status_r <= 8'h00;
		else begin
			status_r[`AOPC_STAT_OVF_A] <= set_a | (status_r[`AOPC_STAT_OVF_A] & !rd_stat);
			status_r[`AOPC_STAT_OVF_B] <= set_b | (status_r[`AOPC_STAT_OVF_B] & !rd_stat);
		end
	end

	wire [7:0] rd_mux =
		reg_req.addr == `AOPC_OFF_CTRL   ? ctrl_r   :
		reg_req.addr == `AOPC_OFF_STATUS ? status_r :
		reg_req.addr == `AOPC_OFF_POWER1 ? power1_r :
		reg_req.addr == `AOPC_OFF_POWER2 ? power2_r :
		reg_req.addr == `AOPC_OFF_SPE    ? spe_r    :
		reg_req.addr == `AOPC_OFF_VOLA   ? vola_r   :
		reg_req.addr == `AOPC_OFF_VOLB   ? volb_r   :
		reg_req.addr == `AOPC_OFF_SPEED  ? {sp_cfg_r, 5'h00, speed_r} : 8'h00;
	always_ff @(posedge clock or negedge rs_b) begin
		if (!rs_b) reg_rdata <= 8'h00;
		else if (reg_req.rd) reg_rdata <= rd_mux;
	end

	// Two-entry buffer; stall by serial port back-pressures decimator
	wire pop = out_valid && out_ready;
	aopc_pair_type push_pair;
	assign push_pair.left  = sat(s_a);
	assign push_pair.right = sat(s_b);
	always_ff @(posedge clock or negedge rs_b) begin
		if (!rs_b) begin
			wp_r  <= 1'b0;
			rp_r  <= 1'b0;
			cnt_r <= 2'h0;
		end else begin
			if (take) wp_r <= !wp_r;
			if (pop) rp_r <= !rp_r;
			cnt_r <= cnt_r + {1'b0, take} - {1'b0, pop};
		end
	end
	always_ff @(posedge clock) begin
		if (take) buf_r[wp_r] <= push_pair;
	end
	wire [1:0] cnt_nxt = cnt_r + {1'b0, take} - {1'b0, pop};
	wire rp_nxt = pop ? !rp_r : rp_r;
	wire [W*2-1:0] head_nxt = (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop)) ? push_pair :
		buf_r[rp_nxt];
	always_ff @(posedge clock or negedge rs_b) begin
		if (!rs_b) begin
			out_valid <= 1'b0;
			out_data  <= '0;
			dec_ready <= 1'b0;
		end else begin
			out_valid <= cnt_nxt != 2'h0;
			out_data  <= head_nxt;
			dec_ready <= cnt_nxt != 2'h2;
		end
	end

	a_hw_lock: assert property (@(posedge clock) disable iff (!rs_b)
		hw_mode_r && reg_req.wr |=> $stable(ctrl_r))
		else $error("register changed in strapped mode");
	a_sat_pos: assert property (@(posedge clock) disable iff (!rs_b)
		take && ovf(s_a) && !s_a[W+1] |-> push_pair.left == `AOPC_SAT_POS)
		else $error("positive saturation wrong");
	a_sat_neg: assert property (@(posedge clock) disable iff (!rs_b)
		take && ovf(s_b) && s_b[W+1] |-> push_pair.right == `AOPC_SAT_NEG)
		else $error("negative saturation wrong");
	a_ovf_flag: assert property (@(posedge clock) disable iff (!rs_b)
		set_a |=> status_r[`AOPC_STAT_OVF_A])
		else $error("overflow flag not set");
	a_frz_hold: assert property (@(posedge clock) disable iff (!rs_b)
		frz_a |=> est_a_r == $past(est_a_r))
		else $error("frozen estimate moved");
	a_hw_dflt: assert property (@(posedge clock) disable iff (!rs_b)
		enter_hw |=> on_a && on_b && !frz_a && !frz_b && vola_r == 8'h00)
		else $error("strapped defaults wrong");
	a_role_pin: assert property (@(posedge clock) disable iff (!rs_b)
		hw_mode_r ##1 hw_mode_r |-> sp_master_r == $past(ms_sync_r[2]))
		else $error("role not from strap");
	a_buf_full: assert property (@(posedge clock) disable iff (!rs_b)
		cnt_r == 2'h2 |-> !dec_ready)
		else $error("buffer full but ready");
	c_ovf: cover property (@(posedge clock) disable iff (!rs_b) set_a);
	c_stall: cover property (@(posedge clock) disable iff (!rs_b) cnt_r == 2'h2);
	c_hw: cover property (@(posedge clock) disable iff (!rs_b) enter_hw);
endmodule : aopc_path

// ### rtl/aopc_defines.svh
// Purpose: Offsets, field positions, reset values and constants for the ADC output path.
// Assumes: Included by its bare name.
// Notes:   Definitions only.
`ifndef AOPC_DEFINES_SVH
`define AOPC_DEFINES_SVH
`define AOPC_OFF_CTRL      8'h06
`define AOPC_OFF_STATUS    8'h20
`define AOPC_OFF_POWER1    8'h02
`define AOPC_OFF_POWER2    8'h03
`define AOPC_OFF_SPE       8'h09
`define AOPC_OFF_VOLA      8'h0E
`define AOPC_OFF_VOLB      8'h0F
`define AOPC_OFF_SPEED     8'h05
`define AOPC_CTRL_FRZ_A    0
`define AOPC_CTRL_ON_A     1
`define AOPC_CTRL_FRZ_B    2
`define AOPC_CTRL_ON_B     3
`define AOPC_CTRL_BOOST_A  4
`define AOPC_CTRL_BOOST_B  5
`define AOPC_CTRL_SOFT     6
`define AOPC_CTRL_ZERO     7
`define AOPC_STAT_OVF_A    0
`define AOPC_STAT_OVF_B    1
`define AOPC_SPE_MONO      0
`define AOPC_SPE_SWAP      1
`define AOPC_SPE_EN        2
`define AOPC_CTRL_RST      8'h00
`define AOPC_CTRL_HW       8'h0A
`define AOPC_POWER1_RST    8'h00
`define AOPC_POWER2_RST    8'h00
`define AOPC_POWER1_HW     8'h00
`define AOPC_POWER2_HW     8'h07
`define AOPC_SPE_RST       8'h00
`define AOPC_VOL_UNITY     8'h00
`define AOPC_SPEED_RST     2'h2
`define AOPC_SAT_POS       24'h7FFFFF
`define AOPC_SAT_NEG       24'h800000
`define AOPC_DITHER_OFS    26'h0000040
`define AOPC_HPF_SHIFT     10
`endif

// ### rtl/aopc_pkg.sv
// Purpose: Types shared by the ADC output path.
// Assumes: Nothing.
// Notes:   Speed modes and sample pair carrier.
package aopc_pkg;
	typedef enum logic [1:0] {
		AOPC_QUARTER,
		AOPC_HALF,
		AOPC_SINGLE,
		AOPC_DOUBLE
	} aopc_speed_type;
	typedef struct packed {
		logic [23:0] left;
		logic [23:0] right;
	} aopc_pair_type;
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [7:0]  wdata;
	} aopc_reg_req_type;
endpackage : aopc_pkg

// ### tb/aopc_host_model.sv
// Purpose: Host side of the byte register port.
// Assumes: One-cycle wr/rd strobes; read data one cycle after rd.
// Notes:   Tasks are called by the bench; always entered just after an edge.
`timescale 1ns/1ps
module aopc_host_model
	import aopc_pkg::*;
(
	input  wire logic             clock,     // Converter clock
	output aopc_reg_req_type      reg_req,   // Request to device
	input  wire logic       [7:0] reg_rdata  // Read data
);
	initial reg_req = '0;
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#1 reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clock);
		#1 reg_req = '0;
	endtask : xfer
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask : write_reg
	// Read data is taken one cycle after the strobe edge, where it stands
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		xfer(1'b0, a, 8'h00);
		d = reg_rdata;
	endtask : read_reg
endmodule : aopc_host_model

// ### tb/tb_adc_output_path_control.sv
// Purpose: Self-checking bench for the ADC output path.
// Assumes: Inputs driven 1 ns after the rising edge.
// Notes:   Filter estimate only compared by relation, not exact value.
`timescale 1ns/1ps
`include "aopc_defines.svh"
module tb_adc_output_path_control import aopc_pkg::*; ();
	logic             clock, rst_b, hw_mode_pin, master_pin;
	aopc_reg_req_type reg_req;
	logic       [7:0] reg_rdata, power1_r, power2_r, rd;
	aopc_pair_type    dec_data, out_data, p, q;
	logic             dec_valid, dec_ready, out_valid, out_ready, sp_master_r, hw_mode_r;
	logic       [1:0] speed_r;
	int               err_count, num_checks;
	aopc_path #(.W(24)) i_dut (.clock(clock), .rst_b(rst_b), .hw_mode_pin(hw_mode_pin),
		.master_pin(master_pin), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.dec_data(dec_data), .dec_valid(dec_valid), .dec_ready(dec_ready),
		.out_data(out_data), .out_valid(out_valid), .out_ready(out_ready),
		.power1_r(power1_r), .power2_r(power2_r), .sp_master_r(sp_master_r),
		.speed_r(speed_r), .hw_mode_r(hw_mode_r));
	aopc_host_model i_host (.clock(clock), .reg_req(reg_req), .reg_rdata(reg_rdata));
	initial clock = 1'b0;
	always #50 clock = ~clock;
	task automatic report_and_stop();
		if (err_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic do_reset(input logic hw, input logic ms);
		rst_b = 1'b0;
		hw_mode_pin = hw;
		master_pin = ms;
		repeat (4) @(posedge clock);
		#1 rst_b = 1'b1;
		repeat (10) @(posedge clock);
		#1;
	endtask : do_reset
	task automatic send(input logic [23:0] l, input logic [23:0] r);
		int n;
		n = 0;
		@(posedge clock) #1;
		dec_data = '{left: l, right: r};
		dec_valid = 1'b1;
		while (dec_ready !== 1'b1 && n < 50) begin
			@(posedge clock) #1;
			n++;
		end
		@(posedge clock) #1;
		dec_valid = 1'b0;
	endtask : send
	task automatic grab(output aopc_pair_type got);
		int n;
		n = 0;
		while (out_valid !== 1'b1 && n < 50) begin
			@(posedge clock) #1;
			n++;
		end
		got = out_data;
		out_ready = 1'b1;
		@(posedge clock) #1;
		out_ready = 1'b0;
	endtask : grab
	task automatic take(input logic [23:0] l, input logic [23:0] r);
		aopc_pair_type got;
		grab(got);
		check("out_data", got, {l, r});
	endtask : take
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		i_host.read_reg(a, rd);
		check("reg_rdata", rd, exp);
	endtask : rdchk
	initial begin
		#500000;
		err_count++;
		report_and_stop();
	end
	initial begin
		err_count = 0;
		num_checks = 0;
		dec_data = '0;
		dec_valid = 1'b0;
		out_ready = 1'b0;
		do_reset(1'b0, 1'b0);
		check("speed_r", speed_r, AOPC_SINGLE);
		check("hw_mode_r", hw_mode_r, 1'b0);
		rdchk(`AOPC_OFF_CTRL, `AOPC_CTRL_RST);
		rdchk(8'h30, 8'h00);
		i_host.write_reg(`AOPC_OFF_POWER1, 8'h5A);
		i_host.write_reg(`AOPC_OFF_POWER2, 8'hA5);
		check("power1_r", power1_r, 8'h5A);
		check("power2_r", power2_r, 8'hA5);
		for (int s = 0; s < 4; s++) begin
			i_host.write_reg(`AOPC_OFF_SPEED, {6'h20, s[1:0]});
			check("speed_r", speed_r, s[1:0]);
		end
		i_host.write_reg(`AOPC_OFF_SPEED, 8'h02);
		// Receiver stalls: two pairs held, then dec_ready low
		send(24'h000100, 24'hFFFF00);
		send(24'h7FFFF0, 24'h000200);
		@(posedge clock) #1;
		check("dec_ready", dec_ready, 1'b0);
		take(24'h000140, 24'hFFFF40);
		take(`AOPC_SAT_POS, 24'h000240);
		rdchk(`AOPC_OFF_STATUS, 8'h01);
		rdchk(`AOPC_OFF_STATUS, 8'h00);
		i_host.write_reg(`AOPC_OFF_VOLA, 8'h01);
		send(24'h000100, 24'h000100);
		take(24'h0000A0, 24'h000140);
		i_host.write_reg(`AOPC_OFF_VOLA, `AOPC_VOL_UNITY);
		i_host.write_reg(`AOPC_OFF_SPE, 8'h06);
		send(24'h000100, 24'h000200);
		take(24'h000240, 24'h000140);
		i_host.write_reg(`AOPC_OFF_SPE, 8'h05);
		send(24'h000100, 24'h000300);
		grab(p);
		check("mono", p.left, p.right);
		i_host.write_reg(`AOPC_OFF_SPE, `AOPC_SPE_RST);
		// Move the estimate with two pairs at a large DC level, then freeze one channel
		i_host.write_reg(`AOPC_OFF_CTRL, 8'h0A);
		repeat (2) begin
			send(24'h400000, 24'h400000);
			grab(p);
		end
		check("dc_sub", p.left === 24'h400040, 1'b0);
		i_host.write_reg(`AOPC_OFF_CTRL, 8'h0B);
		send(24'h000000, 24'h000000);
		grab(p);
		send(24'h000000, 24'h000000);
		grab(q);
		check("frozen", q.left, p.left);
		check("held_sub", p.left === 24'h000040, 1'b0);
		check("unfrozen", q.right === p.right, 1'b0);
		send(`AOPC_SAT_NEG, `AOPC_SAT_NEG);
		take(`AOPC_SAT_NEG, `AOPC_SAT_NEG);
		rdchk(`AOPC_OFF_STATUS, 8'h03);
		// Pin-strapped start, applied as a second reset in mid-run
		do_reset(1'b1, 1'b1);
		check("hw_mode_r", hw_mode_r, 1'b1);
		check("sp_master_r", sp_master_r, 1'b1);
		check("power2_r", power2_r, `AOPC_POWER2_HW);
		rdchk(`AOPC_OFF_CTRL, `AOPC_CTRL_HW);
		i_host.write_reg(`AOPC_OFF_CTRL, 8'h00);
		rdchk(`AOPC_OFF_CTRL, `AOPC_CTRL_HW);
		rdchk(`AOPC_OFF_VOLA, `AOPC_VOL_UNITY);
		report_and_stop();
	end
endmodule : tb_adc_output_path_control
